// ===== dv/dps_config_monitor.sv
`timescale 1ns/100ps
module dps_config_monitor
  import dps_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input dps_frame_type    frame,
  input dps_result_type   result,
  input dps_cfg_type      cfg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // reserved bits must read zero even after all-ones writes
  a_map_resv_zero: assert property ($past(reg_rd) && $past(reg_addr[15:4]) == 12'h035
    |-> (reg_rdata & 8'h88) == 8'h00) else $error("map reserved bit set");
  a_ctrl_resv_zero: assert property ($past(reg_rd) && $past(reg_addr) == 16'h0370
    |-> (reg_rdata & 8'hb2) == 8'h00) else $error("control reserved bit set");
  a_colour_write: assert property (reg_wr && reg_addr == 16'h0378
    |=> cfg.red == $past(reg_wdata[5:4]) && cfg.green == $past(reg_wdata[1:0]))
    else $error("colour field not written");
  a_yellow_write: assert property (reg_wr && reg_addr == 16'h0378
    |=> cfg.yellow == $past(reg_wdata[3:2])) else $error("yellow field not written");
  // read data must stay zero outside the answer cycle
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_below_range: assert property (frame.valid && frame.tos[7:2] < 6'h2c
    |=> result.valid && !result.prio_hit && result.prio == 3'h0) else $error("low code hit");
  // the mirror mode in force at the taking edge decides
  a_mirror_both: assert property (frame.valid && cfg.sniff_and
    |=> result.mirror == $past(frame.port_mirror_en && frame.src_match && frame.dst_match))
    else $error("and-mode mirror wrong");
  a_mirror_either: assert property (frame.valid && !cfg.sniff_and
    |=> result.mirror == $past(frame.port_mirror_en && (frame.src_match || frame.dst_match)))
    else $error("or-mode mirror wrong");
  a_mirror_port_gate: assert property (frame.valid && !frame.port_mirror_en
    |=> !result.mirror) else $error("mirror without port setting");
  a_igmp_host: assert property (frame.valid && frame.is_ipv4 && frame.is_igmp && cfg.igmp_en
    |=> result.to_host) else $error("igmp not sent to host");
  a_mld_host: assert property (frame.valid && frame.is_ipv6 && cfg.mld_en && !cfg.mld_opt
    && frame.next_hdr == 8'h3a |=> result.to_host) else $error("mld not sent to host");
  c_and_mode: cover property (frame.valid && cfg.sniff_and);
  c_mld_opt: cover property (frame.valid && cfg.mld_en && cfg.mld_opt);
  c_read: cover property (reg_rd);
endmodule : dps_config_monitor

bind dps_config dps_config_monitor u_mon (.sys_clk(sys_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .frame(frame), .result(result), .cfg(cfg));

// ===== dv/dps_config_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module dps_config_test
  import dps_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           reset = 1'b1;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic [15:0]    reg_addr = 16'h0000;
  logic [7:0]     reg_wdata = 8'h00;
  logic [7:0]     reg_rdata;
  dps_frame_type  frame = '0;
  dps_result_type result;
  dps_cfg_type    cfg;
  int             fail_count = 0;
  int             checks_done = 0;
  dps_config dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame(frame), .result(result),
    .cfg(cfg));
  always #5 sys_clk = ~sys_clk;
  // strobes drop at the next edge, so every access costs two cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  // result stands one cycle only, so it is judged right after the answer edge
  task automatic send(input dps_frame_type f, input dps_result_type e);
    @(posedge sys_clk);
    frame <= f;
    @(posedge sys_clk);
    frame.valid <= 1'b0;
    #1;
    `CHK("result", e, result)
  endtask : send
  task automatic t_reset();
    for (int i = 0; i < DPS_MAP_N; i++) rd(DPS_MAP_ADDR[i], 8'h00);
    rd(DPS_CTRL_ADDR, 8'h00);
    rd(DPS_WRED_ADDR, 8'h39);
    $display("reset values done");
  endtask : t_reset
  task automatic t_prio();
    logic [5:0] c;
    logic [2:0] h;
    for (int i = 0; i < DPS_MAP_N; i++) begin
      h = i[2:0];
      c = 6'h2c + 6'(2 * i);
      wr(DPS_MAP_ADDR[i], {1'b1, h, 1'b1, ~h});
      rd(DPS_MAP_ADDR[i], {1'b0, h, 1'b0, ~h});
      send('{1, 1, 0, {c, 2'b11}, 0, 0, 0, 0, 0, 0}, '{1, 1, ~h, 0, 0});
      send('{1, 0, 1, {c + 6'h01, 2'b00}, 0, 0, 0, 0, 0, 0}, '{1, 1, h, 0, 0});
    end
    send('{1, 1, 0, 8'haf, 0, 0, 0, 0, 0, 0}, '{1, 0, 0, 0, 0});
    $display("priority lookup done");
  endtask : t_prio
  task automatic t_regs();
    wr(DPS_CTRL_ADDR, 8'hff);
    rd(DPS_CTRL_ADDR, 8'h4d);
    wr(DPS_WRED_ADDR, 8'hff);
    rd(DPS_WRED_ADDR, 8'h3f);
    wr(DPS_WRED_ADDR, 8'h1b);
    rd(DPS_WRED_ADDR, 8'h1b);
    wr(16'h0351, 8'hff);
    rd(16'h0351, 8'h00);
    $display("register access done");
  endtask : t_regs
  task automatic t_snoop();
    logic [7:0] nh [8] = '{8'h01, 8'h3a, 8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c, 8'h11};
    logic       e;
    for (int o = 0; o < 2; o++) begin
      wr(DPS_CTRL_ADDR, (o == 1) ? 8'h0c : 8'h04);
      for (int k = 0; k < 8; k++) begin
        e = (o == 0) ? (k < 2) : (k > 1 && k < 7);
        send('{1, 0, 1, 8'h00, nh[k], 0, 0, 0, 0, 0}, '{1, 0, 0, e, 0});
        send('{1, 0, 1, 8'h00, 0, nh[k], 0, 0, 0, 0}, '{1, 0, 0, e, 0});
      end
    end
    wr(DPS_CTRL_ADDR, 8'h40);
    send('{1, 0, 1, 8'h00, 8'h3a, 0, 0, 0, 0, 0}, '{1, 0, 0, 0, 0});
    send('{1, 1, 0, 8'h00, 0, 0, 1, 0, 0, 0}, '{1, 0, 0, 1, 0});
    wr(DPS_CTRL_ADDR, 8'h00);
    send('{1, 1, 0, 8'h00, 0, 0, 1, 0, 0, 0}, '{1, 0, 0, 0, 0});
    $display("snooping done");
  endtask : t_snoop
  task automatic t_mirror();
    logic e;
    for (int s = 0; s < 2; s++) begin
      wr(DPS_CTRL_ADDR, {7'h00, s[0]});
      for (int m = 0; m < 8; m++) begin
        e = m[2] & ((s == 1) ? (m[0] & m[1]) : (m[0] | m[1]));
        send('{1, 1, 0, 8'h00, 0, 0, 0, m[0], m[1], m[2]}, '{1, 0, 0, 0, e});
      end
    end
    $display("mirror filter done");
  endtask : t_mirror
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // a hang past this bound counts against the run
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_prio();
    t_regs();
    t_snoop();
    t_mirror();
    finish_test();
  end
endmodule : dps_config_test

// ===== hw/dps_config.sv
`timescale 1ns/100ps
module dps_config
  import dps_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           reset,
  input  wire logic [15:0]    reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [7:0]     reg_rdata,
  input  dps_frame_type       frame,
  output dps_result_type      result,
  output dps_cfg_type         cfg
);

  dps_state_type state;
  dps_state_type next_state;

  // finds which mapping byte an address selects; used by write and read
  function automatic logic [DPS_IDX_W:0] map_decode(input logic [15:0] addr);
    logic [DPS_IDX_W:0] r;
    r = '0;
    for (int i = 0; i < DPS_MAP_N; i++) begin
      if (addr == DPS_MAP_ADDR[i]) begin
        r = {1'b1, DPS_IDX_W'(i)};
      end
    end
    return r;
  endfunction : map_decode

  // mld recognition; a hop-by-hop header is looked through once only
  function automatic logic nh_hit(input logic opt, input logic [7:0] nh);
    if (opt) begin
      return (nh == DPS_NH_RTE) || (nh == DPS_NH_FRAG) || (nh == DPS_NH_ESP) ||
             (nh == DPS_NH_AH)  || (nh == DPS_NH_DST);
    end
    return (nh == DPS_NH_ICMP) || (nh == DPS_NH_ICM6);
  endfunction : nh_hit

  function automatic logic mld_match(input logic opt, input logic [7:0] nh,
                                     input logic [7:0] hbh);
    return nh_hit(opt, nh) || ((nh == DPS_NH_HOP) && nh_hit(opt, hbh));
  endfunction : mld_match

  logic [DPS_IDX_W:0] wr_sel;
  logic [DPS_IDX_W:0] rd_sel;
  logic [5:0]         code;
  logic [DPS_IDX_W-1:0] pair_idx;
  logic               in_range;
  logic               igmp_hit;
  logic               mld_hit;
  logic               port_hit;

  // address decode and classification terms
  always_comb begin
    wr_sel   = map_decode(reg_addr);
    rd_sel   = wr_sel;
    code     = frame.tos[DPS_CODE_MSB:DPS_CODE_LSB];
    in_range = code >= DPS_CODE_LO;
    pair_idx = code[DPS_PAIR_MSB:DPS_PAIR_LSB] - DPS_IDX_BASE;
    igmp_hit = frame.is_ipv4 && frame.is_igmp && state.cfg.igmp_en;
    mld_hit  = frame.is_ipv6 && state.cfg.mld_en &&
               mld_match(state.cfg.mld_opt, frame.next_hdr, frame.hbh_next_hdr);
    // and-mode for full pair sniffing, or-mode lets rx-only sniff work
    port_hit = state.cfg.sniff_and ? (frame.src_match && frame.dst_match)
                                   : (frame.src_match || frame.dst_match);
  end

  // single next-state process; register writes take effect next cycle
  always_comb begin
    next_state = state;
    // register writes; only the defined fields are stored
    if (reg_wr) begin
      if (wr_sel[DPS_IDX_W]) begin
        next_state.map_hi[wr_sel[DPS_IDX_W-1:0]] =
          reg_wdata[DPS_MAP_HI_LSB +: DPS_PRIO_W];
        next_state.map_lo[wr_sel[DPS_IDX_W-1:0]] =
          reg_wdata[DPS_MAP_LO_LSB +: DPS_PRIO_W];
      end else if (reg_addr == DPS_CTRL_ADDR) begin
        next_state.cfg.igmp_en   = reg_wdata[DPS_CTRL_IGMP];
        next_state.cfg.mld_opt   = reg_wdata[DPS_CTRL_MLDOP];
        next_state.cfg.mld_en    = reg_wdata[DPS_CTRL_MLDEN];
        next_state.cfg.sniff_and = reg_wdata[DPS_CTRL_SNIFF];
      end else if (reg_addr == DPS_WRED_ADDR) begin
        next_state.cfg.red    = reg_wdata[DPS_WRED_RED +: DPS_COL_W];
        next_state.cfg.yellow = reg_wdata[DPS_WRED_YEL +: DPS_COL_W];
        next_state.cfg.green  = reg_wdata[DPS_WRED_GRN +: DPS_COL_W];
      end
    end
    // read data stands for exactly one cycle; unmapped reads give zero
    next_state.rdata = '0;
    if (reg_rd) begin
      if (rd_sel[DPS_IDX_W]) begin
        next_state.rdata[DPS_MAP_HI_LSB +: DPS_PRIO_W] =
          state.map_hi[rd_sel[DPS_IDX_W-1:0]];
        next_state.rdata[DPS_MAP_LO_LSB +: DPS_PRIO_W] =
          state.map_lo[rd_sel[DPS_IDX_W-1:0]];
      end else if (reg_addr == DPS_CTRL_ADDR) begin
        next_state.rdata[DPS_CTRL_IGMP]  = state.cfg.igmp_en;
        next_state.rdata[DPS_CTRL_MLDOP] = state.cfg.mld_opt;
        next_state.rdata[DPS_CTRL_MLDEN] = state.cfg.mld_en;
        next_state.rdata[DPS_CTRL_SNIFF] = state.cfg.sniff_and;
      end else if (reg_addr == DPS_WRED_ADDR) begin
        next_state.rdata[DPS_WRED_RED +: DPS_COL_W] = state.cfg.red;
        next_state.rdata[DPS_WRED_YEL +: DPS_COL_W] = state.cfg.yellow;
        next_state.rdata[DPS_WRED_GRN +: DPS_COL_W] = state.cfg.green;
      end
    end
    // one-cycle classification result; uses settings before a same-cycle write
    next_state.res = '0;
    if (frame.valid) begin
      next_state.res.valid = 1'b1;
      if ((frame.is_ipv4 || frame.is_ipv6) && in_range) begin
        next_state.res.prio_hit = 1'b1;
        next_state.res.prio = code[DPS_ODD_BIT] ? state.map_hi[pair_idx]
                                      : state.map_lo[pair_idx];
      end
      next_state.res.to_host = igmp_hit || mld_hit;
      // the global byte alone never mirrors
      next_state.res.mirror = frame.port_mirror_en && port_hit;
    end
  end

  // state register; reset loads documented defaults
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state            <= '0;
      state.cfg.red    <= DPS_RED_RST;
      state.cfg.yellow <= DPS_YEL_RST;
      state.cfg.green  <= DPS_GRN_RST;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign result    = state.res;
  assign cfg       = state.cfg;

endmodule : dps_config

// ===== hw/dps_pkg.sv
// Operation
// - even codes 0x2c..0x3e take priority from map byte bits 2:0
// - odd codes 0x2d..0x3f take priority from map byte bits 6:4
// - priority fields reset to zero, read-write; bits 7 and 3 read zero
// - igmp snooping enable set sends every igmp packet to host port
// - mld snooping enable set sends every mld packet to host port
// - option clear: next header 1 or 58, or 0 then hop-by-hop 1 or 58
// - option set: next header 43,44,50,51,60, or 0 then hop-by-hop same set
// - sniff select one: both source and destination port must match
// - sniff select zero (reset): source or destination match mirrors
// - mirroring needs the per-port ingress mirror setting as well
// - red colour code in bits 5:4, read-write, reset 11b
// - yellow colour code in bits 3:2, read-write, reset 10b
// - green colour code in bits 1:0, read-write, reset 01b
package dps_pkg;

  localparam int          DPS_MAP_N     = 10;
  localparam int          DPS_IDX_W     = 4;
  localparam logic [5:0]  DPS_CODE_LO   = 6'h2c;
  localparam logic [3:0]  DPS_IDX_BASE  = 4'h6;   // code[4:1] of first pair

  // where the service code sits in the tos byte, and how it picks a pair
  localparam int DPS_CODE_MSB = 7;
  localparam int DPS_CODE_LSB = 2;
  localparam int DPS_PAIR_MSB = 4;
  localparam int DPS_PAIR_LSB = 1;
  localparam int DPS_ODD_BIT  = 0;
  localparam int DPS_PRIO_W   = 3;
  localparam int DPS_COL_W    = 2;

  // mapping byte offsets, pair 0x2c/0x2d first
  localparam logic [15:0] DPS_MAP_ADDR [DPS_MAP_N] = '{
    16'h0350, 16'h0357, 16'h0358, 16'h0359, 16'h035a,
    16'h035b, 16'h035c, 16'h035d, 16'h035e, 16'h035f};
  localparam logic [15:0] DPS_CTRL_ADDR = 16'h0370;
  localparam logic [15:0] DPS_WRED_ADDR = 16'h0378;

  // field positions of a mapping byte
  localparam int DPS_MAP_HI_LSB = 4;
  localparam int DPS_MAP_LO_LSB = 0;
  // control byte bits
  localparam int DPS_CTRL_IGMP  = 6;
  localparam int DPS_CTRL_MLDOP = 3;
  localparam int DPS_CTRL_MLDEN = 2;
  localparam int DPS_CTRL_SNIFF = 0;
  // colour byte fields
  localparam int DPS_WRED_RED   = 4;
  localparam int DPS_WRED_YEL   = 2;
  localparam int DPS_WRED_GRN   = 0;

  localparam logic [1:0] DPS_RED_RST = 2'h3;
  localparam logic [1:0] DPS_YEL_RST = 2'h2;
  localparam logic [1:0] DPS_GRN_RST = 2'h1;
  localparam logic [2:0] DPS_PRIO_RST = 3'h0;

  // ipv6 next-header codes
  localparam logic [7:0] DPS_NH_HOP  = 8'h00;
  localparam logic [7:0] DPS_NH_ICMP = 8'h01;
  localparam logic [7:0] DPS_NH_ICM6 = 8'h3a;   // 58
  localparam logic [7:0] DPS_NH_RTE  = 8'h2b;   // 43
  localparam logic [7:0] DPS_NH_FRAG = 8'h2c;   // 44
  localparam logic [7:0] DPS_NH_ESP  = 8'h32;   // 50
  localparam logic [7:0] DPS_NH_AH   = 8'h33;   // 51
  localparam logic [7:0] DPS_NH_DST  = 8'h3c;   // 60

  typedef struct packed {
    logic       valid;
    logic       is_ipv4;
    logic       is_ipv6;
    logic [7:0] tos;            // tos or traffic class byte
    logic [7:0] next_hdr;
    logic [7:0] hbh_next_hdr;
    logic       is_igmp;
    logic       src_match;
    logic       dst_match;
    logic       port_mirror_en; // per-port ingress mirror setting
  } dps_frame_type;

  typedef struct packed {
    logic       valid;
    logic       prio_hit;       // code fell in this bank's range
    logic [2:0] prio;
    logic       to_host;
    logic       mirror;
  } dps_result_type;

  typedef struct packed {
    logic       igmp_en;
    logic       mld_opt;
    logic       mld_en;
    logic       sniff_and;
    logic [1:0] red;
    logic [1:0] yellow;
    logic [1:0] green;
  } dps_cfg_type;

  typedef struct packed {
    logic [DPS_MAP_N-1:0][2:0] map_hi;
    logic [DPS_MAP_N-1:0][2:0] map_lo;
    dps_cfg_type               cfg;
    logic [7:0]                rdata;
    dps_result_type            res;
  } dps_state_type;

endpackage : dps_pkg
